// ### logic/forward_pkg.sv
package forward_pkg;

	// ----------------------------------------------------------------
	// Channel sizing and count scales
	// ----------------------------------------------------------------
	localparam int              NUM_CH          = 8;
	localparam int              COUNT_W         = 16;
	localparam logic signed [18:0] FULL_POS     = 19'sh04E20;  // +20000 counts
	localparam logic signed [18:0] FULL_NEG     = -19'sh04E20; // -20000 counts
	localparam logic signed [18:0] HALF_POS     = 19'sh02710;  // 10000 counts
	localparam logic [8:0]      SPAN_SIGNED     = 9'h190;      // 40000 / 100 per percent
	localparam logic [8:0]      SPAN_POSITIVE   = 9'h0C8;      // 20000 / 100 per percent

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int              CLK_PERIOD_NS   = 50;
	localparam int              TICK_MS         = 100;
	localparam int              TICK_CYCLES_DOC = TICK_MS * 1000000 / CLK_PERIOD_NS;
	localparam logic [9:0]      PERIOD_MAX      = 10'h384;     // 900 units
	localparam logic [9:0]      HEARTBEAT_UNITS = 10'h258;     // 600 units, 60 s
	localparam logic [6:0]      PERCENT_MAX     = 7'h64;       // 100 percent

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [11:0]     CTRL_OFS        = 12'h000;
	localparam logic [11:0]     STATUS_OFS      = 12'h004;
	localparam logic [3:0]      CHAN_PAGE       = 4'h1;        // 0x100 + ch * 0x20
	localparam logic [2:0]      CH_CFG_IDX      = 3'h0;        // +0x00
	localparam logic [2:0]      CH_PERIOD_IDX   = 3'h1;        // +0x04
	localparam logic [2:0]      CH_ADDR_IDX     = 3'h2;        // +0x08
	localparam logic [2:0]      CH_HREG_IDX     = 3'h3;        // +0x0C
	localparam logic [2:0]      CH_REF_IDX      = 3'h4;        // +0x10
	localparam logic [2:0]      CH_LIVE_IDX     = 3'h5;        // +0x14

	// CFG fields
	localparam int              CFG_PCT_LSB     = 0;           // [6:0]
	localparam int              CFG_MODE_LSB    = 8;           // [9:8]
	localparam int              CFG_INSIGNED_BIT = 12;
	// CTRL fields
	localparam int              CTRL_ENABLE_BIT = 0;
	localparam int              CTRL_RESTORE_BIT = 1;
	localparam logic            CTRL_ENABLE_RST = 1'b1;

	typedef enum logic [1:0] {
		MAP_POSITIVE_DIRECT,
		MAP_SIGNED_DIRECT,
		MAP_SIGNED_TO_POSITIVE,
		MAP_POSITIVE_TO_SIGNED
	} map_mode_e;

endpackage : forward_pkg

// ### logic/count_mapper.sv
`timescale 1ns/1ps
module count_mapper
	import forward_pkg::*;
(
	input  wire logic signed [15:0] in_count,
	input  wire map_mode_e          mode,
	output logic signed [15:0]      out_count
);

	// ----------------------------------------------------------------
	// Scale arithmetic, widened so nothing wraps
	// ----------------------------------------------------------------
	wire logic signed [18:0] x        = {{3{in_count[15]}}, in_count};
	wire logic signed [18:0] s2p_raw  = (x + FULL_POS) >>> 1;
	wire logic signed [18:0] p2s_raw  = (x <<< 1) - FULL_POS;

	// Saturating clamp into a destination range
	function automatic logic signed [15:0] clamp(input logic signed [18:0] v,
	                                               input logic signed [18:0] lo);
		logic signed [18:0] r;
		r = v;
		if (v < lo)
			r = lo;
		else if (v > FULL_POS)
			r = FULL_POS;
		return r[15:0];
	endfunction : clamp

	// Mode selection; every result saturates to its range
	always_comb
	begin
		case (mode)
			MAP_POSITIVE_DIRECT:    out_count = clamp(x, 19'sh00000);
			MAP_SIGNED_DIRECT:      out_count = clamp(x, FULL_NEG);
			MAP_SIGNED_TO_POSITIVE: out_count = clamp(s2p_raw, 19'sh00000);
			MAP_POSITIVE_TO_SIGNED: out_count = clamp(p2s_raw, FULL_NEG);
			default:                out_count = 16'sh0000;
		endcase
	end

endmodule : count_mapper

// ### logic/input_forwarding_scheduler.sv
// Contract
// - Forwarded messages go out over TCP only
// - Period in 100 ms units, 1-900, 0 off
// - Span-only channels heartbeat every 600 units
// - Send when change reaches span percentage
// - Period-only sends live value each expiry
// - Span-only heartbeat carries stored reference
// - Periodic send in dual mode refreshes reference
// - Zero target address makes channel inactive
// - Zero span and zero period: silent
// - Message writes the target holding register
// - Positive direct: pass 0-20000, clip negatives
// - Signed direct: pass -20000..+20000
// - Signed to positive: (x + 20000) / 2
// - Positive to signed: 2x - 20000
// - Factory restore clears all mapping settings
// - Retry and resume after link loss
// - Counts normalised to 20000 full scale
//
// The register addresses and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
module input_forwarding_scheduler
	import forward_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYCLES_DOC,
	parameter int CHANNELS    = NUM_CH
)
(
	input  wire logic                REF_CLK,
	input  wire logic                RST_N,
	input  wire logic                CE,
	// AHB-Lite slave
	input  wire logic                HSEL,
	input  wire logic [31:0]         HADDR,
	input  wire logic [1:0]          HTRANS,
	input  wire logic                HWRITE,
	input  wire logic [2:0]          HSIZE,
	input  wire logic [31:0]         HWDATA,
	input  wire logic                HREADY,
	output logic [31:0]              HRDATA,
	output logic                     HREADYOUT,
	output logic                     HRESP,
	// Normalised input samples
	input  wire logic                IN_VALID,
	input  wire logic [2:0]          IN_CHAN,
	input  wire logic signed [15:0]  IN_COUNT,
	// Modbus TCP client side
	input  wire logic                LINK_UP,
	input  wire logic                MSG_READY,
	output logic                     MSG_VALID,
	output logic [2:0]               MSG_CHAN,
	output logic [31:0]              MSG_TARGET_ADDR,
	output logic [15:0]              MSG_TARGET_REG,
	output logic signed [15:0]       MSG_DATA
);

	// ----------------------------------------------------------------
	// Per-channel state and configuration
	// ----------------------------------------------------------------
	logic [6:0]         pct_reg     [CHANNELS];
	map_mode_e          mode_reg    [CHANNELS];
	logic               insig_reg   [CHANNELS];
	logic [9:0]         period_reg  [CHANNELS];
	logic [31:0]        taddr_reg   [CHANNELS];
	logic [15:0]        treg_reg    [CHANNELS];
	logic signed [15:0] ref_reg     [CHANNELS];
	logic signed [15:0] live_reg    [CHANNELS];
	logic [9:0]         cnt_reg     [CHANNELS];

	logic               enable_reg;
	logic [15:0]        sent_reg;
	logic [2:0]         scan_reg;
	logic [31:0]        tick_reg;
	logic               wr_pend_reg;
	logic [11:0]        wr_addr_reg;

	// ----------------------------------------------------------------
	// Address decoding
	// ----------------------------------------------------------------
	function automatic logic in_chan_page(input logic [11:0] a);
		return a[11:8] == CHAN_PAGE;
	endfunction : in_chan_page

	function automatic logic [2:0] chan_of(input logic [11:0] a);
		return a[7:5];
	endfunction : chan_of

	function automatic logic [2:0] field_of(input logic [11:0] a);
		return a[4:2];
	endfunction : field_of

	// Address phase accepted only for NONSEQ/SEQ while the bus is ready
	wire logic        ahb_take   = HSEL && HREADY && HTRANS[1];
	wire logic        rd_take    = ahb_take && !HWRITE;
	wire logic        wr_take    = ahb_take && HWRITE;
	wire logic [11:0] rd_addr    = HADDR[11:0];
	wire logic [2:0]  rd_ch      = chan_of(rd_addr);
	wire logic [2:0]  rd_fld     = field_of(rd_addr);
	wire logic        rd_is_ch   = in_chan_page(rd_addr);
	wire logic [2:0]  wr_ch      = chan_of(wr_addr_reg);
	wire logic [2:0]  wr_fld     = field_of(wr_addr_reg);
	wire logic        wr_is_ch   = wr_pend_reg && in_chan_page(wr_addr_reg);
	wire logic        wr_ctrl    = wr_pend_reg && (wr_addr_reg == CTRL_OFS);
	wire logic        restore    = wr_ctrl && HWDATA[CTRL_RESTORE_BIT];
	wire logic [9:0]  wr_period  = (HWDATA[9:0] > PERIOD_MAX) ? PERIOD_MAX : HWDATA[9:0];
	wire logic [6:0]  wr_pct     = (HWDATA[6:0] > PERCENT_MAX) ? PERCENT_MAX : HWDATA[6:0];

	// Read data selection; unmapped words read as zero
	logic [31:0] rd_data;
	always_comb
	begin
		rd_data = 32'h0000_0000;
		if (rd_is_ch)
		begin
			case (rd_fld)
				CH_CFG_IDX:    rd_data = {19'h0, insig_reg[rd_ch], 2'h0, mode_reg[rd_ch],
				                          1'b0, pct_reg[rd_ch]};
				CH_PERIOD_IDX: rd_data = {22'h0, period_reg[rd_ch]};
				CH_ADDR_IDX:   rd_data = taddr_reg[rd_ch];
				CH_HREG_IDX:   rd_data = {16'h0, treg_reg[rd_ch]};
				CH_REF_IDX:    rd_data = {{16{ref_reg[rd_ch][15]}}, ref_reg[rd_ch]};
				CH_LIVE_IDX:   rd_data = {{16{live_reg[rd_ch][15]}}, live_reg[rd_ch]};
				default:       rd_data = 32'h0000_0000;
			endcase
		end
		else if (rd_addr == CTRL_OFS)
			rd_data = {31'h0, enable_reg};
		else if (rd_addr == STATUS_OFS)
			rd_data = {14'h0, LINK_UP, MSG_VALID, sent_reg};
	end

	// ----------------------------------------------------------------
	// Bus slave: zero wait states, always OKAY
	// ----------------------------------------------------------------
	// Write data lands one cycle after its address phase
	always_ff @(posedge REF_CLK)
	begin
		if (!RST_N)
		begin
			HRDATA      <= 32'h0000_0000;
			HREADYOUT   <= 1'b1;
			HRESP       <= 1'b0;
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 12'h000;
		end
		else if (CE)
		begin
			wr_pend_reg <= wr_take;
			wr_addr_reg <= HADDR[11:0];
			if (rd_take)
				HRDATA <= rd_data;
		end
	end

	// Global enable
	always_ff @(posedge REF_CLK)
	begin
		if (!RST_N)
			enable_reg <= CTRL_ENABLE_RST;
		else if (CE && wr_ctrl)
			enable_reg <= HWDATA[CTRL_ENABLE_BIT];
	end

	// ----------------------------------------------------------------
	// 100 ms time base
	// ----------------------------------------------------------------
	wire logic tick = (tick_reg == 32'(TICK_CYCLES - 1));

	always_ff @(posedge REF_CLK)
	begin
		if (!RST_N)
			tick_reg <= 32'h0000_0000;
		else if (CE)
			tick_reg <= tick ? 32'h0000_0000 : tick_reg + 32'h0000_0001;
	end

	// ----------------------------------------------------------------
	// Scan of one channel per cycle
	// ----------------------------------------------------------------
	wire logic [6:0]         s_pct    = pct_reg[scan_reg];
	wire logic [9:0]         s_period = period_reg[scan_reg];
	wire logic signed [15:0] s_live   = live_reg[scan_reg];
	wire logic signed [15:0] s_ref    = ref_reg[scan_reg];
	wire logic               s_active = enable_reg && (taddr_reg[scan_reg] != 32'h0)
	                                    && ((s_pct != 7'h00) || (s_period != 10'h000));
	// Zero period with a threshold falls back to the heartbeat
	wire logic [9:0]         s_eff    = (s_period != 10'h000) ? s_period : HEARTBEAT_UNITS;

	// Change since the reference, against threshold in counts
	wire logic signed [16:0] s_diff   = 17'(s_live) - 17'(s_ref);
	wire logic [16:0]        s_delta  = s_diff[16] ? 17'(-s_diff) : 17'(s_diff);
	wire logic [8:0]         s_unit   = insig_reg[scan_reg] ? SPAN_SIGNED : SPAN_POSITIVE;
	wire logic [16:0]        s_thr    = 17'(s_pct) * 17'(s_unit);

	wire logic per_due  = s_active && (cnt_reg[scan_reg] >= s_eff);
	wire logic span_due = s_active && (s_pct != 7'h00) && (s_delta >= s_thr);
	// Silence when inactive; events held until the link returns
	wire logic out_free = !MSG_VALID || MSG_READY;
	wire logic send_now = (per_due || span_due) && out_free && LINK_UP;
	// Heartbeat of span-only mode repeats the reference
	wire logic send_live = span_due || (s_period != 10'h000);
	wire logic signed [15:0] send_val = send_live ? s_live : s_ref;

	logic signed [15:0] mapped;
	count_mapper u_mapper
	(
		.in_count  (send_val),
		.mode      (mode_reg[scan_reg]),
		.out_count (mapped)
	);

	always_ff @(posedge REF_CLK)
	begin
		if (!RST_N)
			scan_reg <= 3'h0;
		else if (CE)
			scan_reg <= (scan_reg == 3'(CHANNELS - 1)) ? 3'h0 : scan_reg + 3'h1;
	end

	// ----------------------------------------------------------------
	// Message output toward the TCP client
	// ----------------------------------------------------------------
	// Only TCP client requests are issued; no datagram path exists
	always_ff @(posedge REF_CLK)
	begin
		if (!RST_N)
		begin
			MSG_VALID       <= 1'b0;
			MSG_CHAN        <= 3'h0;
			MSG_TARGET_ADDR <= 32'h0000_0000;
			MSG_TARGET_REG  <= 16'h0000;
			MSG_DATA        <= 16'sh0000;
			sent_reg        <= 16'h0000;
		end
		else if (CE)
		begin
			if (send_now)
			begin
				MSG_VALID       <= 1'b1;
				MSG_CHAN        <= scan_reg;
				MSG_TARGET_ADDR <= taddr_reg[scan_reg];
				MSG_TARGET_REG  <= treg_reg[scan_reg];
				MSG_DATA        <= mapped;
				sent_reg        <= sent_reg + 16'h0001;
			end
			else if (MSG_READY)
				MSG_VALID <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Per-channel timers, references and live samples
	// ----------------------------------------------------------------
	// Counters saturate so a missed expiry during an outage still fires;
	// a config write restarts them, else an idle channel fires at once
	always_ff @(posedge REF_CLK)
	begin
		if (!RST_N)
		begin
			for (int i = 0; i < CHANNELS; i++)
			begin
				cnt_reg[i]  <= 10'h000;
				ref_reg[i]  <= 16'sh0000;
				live_reg[i] <= 16'sh0000;
			end
		end
		else if (CE)
		begin
			for (int i = 0; i < CHANNELS; i++)
			begin
				if (send_now && (scan_reg == 3'(i)))
				begin
					cnt_reg[i] <= 10'h000;
					ref_reg[i] <= send_val;
				end
				else if (wr_is_ch && (wr_ch == 3'(i))) cnt_reg[i] <= 10'h000;
				else if (tick && (cnt_reg[i] != 10'h3FF))
					cnt_reg[i] <= cnt_reg[i] + 10'h001;
				if (IN_VALID && (IN_CHAN == 3'(i)))
					live_reg[i] <= IN_COUNT;
			end
		end
	end

	// ----------------------------------------------------------------
	// Mapping configuration
	// ----------------------------------------------------------------
	// Defaults leave every channel inactive
	always_ff @(posedge REF_CLK)
	begin
		if (!RST_N || (CE && restore))
		begin
			for (int i = 0; i < CHANNELS; i++)
			begin
				pct_reg[i]    <= 7'h00;
				mode_reg[i]   <= MAP_POSITIVE_DIRECT;
				insig_reg[i]  <= 1'b0;
				period_reg[i] <= 10'h000;
				taddr_reg[i]  <= 32'h0000_0000;
				treg_reg[i]   <= 16'h0000;
			end
		end
		else if (CE && wr_is_ch)
		begin
			case (wr_fld)
				CH_CFG_IDX:
				begin
					pct_reg[wr_ch]   <= wr_pct;
					mode_reg[wr_ch]  <= map_mode_e'(HWDATA[CFG_MODE_LSB +: 2]);
					insig_reg[wr_ch] <= HWDATA[CFG_INSIGNED_BIT];
				end
				CH_PERIOD_IDX: period_reg[wr_ch] <= wr_period;
				CH_ADDR_IDX:   taddr_reg[wr_ch]  <= HWDATA;
				CH_HREG_IDX:   treg_reg[wr_ch]   <= HWDATA[15:0];
				default:       treg_reg[wr_ch]   <= treg_reg[wr_ch];
			endcase
		end
	end

endmodule : input_forwarding_scheduler

// ### verif/forward_asserts.sv
`timescale 1ns/1ps
module forward_asserts
	import forward_pkg::*;
#(
	parameter int	TICK_CYCLES = 4,
	parameter int	CHANNELS = 8
)
(
	input wire logic	REF_CLK,
	input wire logic	RST_N,
	input wire logic	CE,
	input wire logic	HSEL,
	input wire logic [31:0]	HADDR,
	input wire logic [1:0]	HTRANS,
	input wire logic	HWRITE,
	input wire logic [2:0]	HSIZE,
	input wire logic [31:0]	HWDATA,
	input wire logic	HREADY,
	input wire logic [31:0]	HRDATA,
	input wire logic	HREADYOUT,
	input wire logic	HRESP,
	input wire logic	IN_VALID,
	input wire logic [2:0]	IN_CHAN,
	input wire logic signed [15:0]	IN_COUNT,
	input wire logic	LINK_UP,
	input wire logic	MSG_READY,
	input wire logic	MSG_VALID,
	input wire logic [2:0]	MSG_CHAN,
	input wire logic [31:0]	MSG_TARGET_ADDR,
	input wire logic [15:0]	MSG_TARGET_REG,
	input wire logic signed [15:0]	MSG_DATA
);
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RST_N);

	// ----
	// Bus request decode
	// ----
	wire	rd_take = HSEL && HREADY && HTRANS[1] && !HWRITE && CE;
	wire	rd_unmapped = rd_take && HADDR[31:12] == 20'h0 && HADDR[11:9] != 3'h0;
	wire	rd_status = rd_take && HADDR == 32'h0000_0004;
	// Link must be down for three edges so an in-flight decision is excused
	sequence link_down_idle;
		!LINK_UP [*3] ##0 !MSG_VALID;
	endsequence

	a_ready_always: assert property (HREADYOUT == 1'b1) else $error("wait state seen");
	a_resp_okay: assert property (HRESP == 1'b0) else $error("error response seen");
	a_unmapped_zero: assert property (rd_unmapped |=> HRDATA == 32'h0)
		else $error("unmapped read not zero");
	a_status_link: assert property (rd_status |=> HRDATA[17] == $past(LINK_UP))
		else $error("status link bit wrong");
	a_msg_hold: assert property (MSG_VALID && !MSG_READY |=> MSG_VALID && $stable(MSG_DATA)
		&& $stable(MSG_CHAN) && $stable(MSG_TARGET_REG)) else $error("message changed while held");
	a_link_quiet: assert property (link_down_idle |=> !MSG_VALID)
		else $error("message raised while link down");
	a_zero_addr: assert property (MSG_VALID |-> MSG_TARGET_ADDR != 32'h0)
		else $error("message to zero address");
	a_data_range: assert property (MSG_VALID |-> MSG_DATA >= -20000 && MSG_DATA <= 20000)
		else $error("message data out of range");

	c_accept: cover property (MSG_VALID && MSG_READY);
	c_stall: cover property (MSG_VALID && !MSG_READY);
	c_unmapped: cover property (rd_unmapped);
endmodule : forward_asserts

bind input_forwarding_scheduler forward_asserts #(.TICK_CYCLES(TICK_CYCLES), .CHANNELS(CHANNELS))
	u_chk (.REF_CLK(REF_CLK), .RST_N(RST_N), .CE(CE), .HSEL(HSEL), .HADDR(HADDR),
	.HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY),
	.HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .IN_VALID(IN_VALID),
	.IN_CHAN(IN_CHAN), .IN_COUNT(IN_COUNT), .LINK_UP(LINK_UP), .MSG_READY(MSG_READY),
	.MSG_VALID(MSG_VALID), .MSG_CHAN(MSG_CHAN), .MSG_TARGET_ADDR(MSG_TARGET_ADDR),
	.MSG_TARGET_REG(MSG_TARGET_REG), .MSG_DATA(MSG_DATA));

// ### verif/msg_sink.sv
`timescale 1ns/1ps
module msg_sink
(
	input wire logic	clk,
	input wire logic	rst_n,
	input wire logic	link_en,
	input wire logic	stall,
	input wire logic	msg_valid,
	input wire logic [2:0]	msg_chan,
	input wire logic [31:0]	msg_addr,
	input wire logic [15:0]	msg_reg,
	input wire logic [15:0]	msg_data,
	output logic	link_up,
	output logic	msg_ready,
	output logic [31:0]	got_addr,
	output logic [15:0]	got_reg,
	output logic [15:0]	got_data,
	output int	cnt [8]
);
	// ----
	// Remote output module seen through the TCP client
	// ----
	// Fixed address, one socket per source, no other master writes the output
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			link_up <= 1'b0;
			msg_ready <= 1'b0;
			cnt <= '{default: 0};
		end
		else
		begin
			link_up <= link_en;
			// Slow mode takes every other cycle; nothing is taken while offline
			msg_ready <= link_en && (!stall || !msg_ready);
			if (msg_valid && msg_ready)
			begin
				cnt[msg_chan] <= cnt[msg_chan] + 1;
				got_addr <= msg_addr;
				got_reg <= msg_reg;
				got_data <= msg_data;
			end
		end
	end
endmodule : msg_sink

// ### verif/testbench.sv
`timescale 1ns/1ps
module testbench;
	import forward_pkg::*;
	localparam int	TK = 10;
	logic	clk, rst_n, hsel, hwrite, in_valid, link_en, stall;
	logic [31:0]	haddr, hwdata;
	logic [1:0]	htrans;
	logic [2:0]	in_chan;
	logic signed [15:0]	in_count;
	wire	hready_out, hresp, link_up, msg_ready, msg_valid;
	wire [2:0]	msg_chan;
	wire [31:0]	hrdata, msg_addr, got_addr;
	wire [15:0]	msg_reg, got_reg, got_data;
	wire signed [15:0]	msg_data;
	int	cnt [8];
	int	n_fail, checks, c, el;
	// Mapping table: mode, input, expected output
	logic [1:0]	mm [11] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h2, 2'h3, 2'h3, 2'h3, 2'h3};
	logic [15:0]	mi [11] = '{16'hFE0C, 16'h4E20, 16'hB1E0, 16'h61A8, 16'hB1E0, 16'h0000,
		16'h4E20, 16'h0000, 16'h2710, 16'h4E20, 16'h7530};
	logic [15:0]	mo [11] = '{16'h0000, 16'h4E20, 16'hB1E0, 16'h4E20, 16'h0000, 16'h2710,
		16'h4E20, 16'hB1E0, 16'h0000, 16'h4E20, 16'h4E20};

	input_forwarding_scheduler #(.TICK_CYCLES(TK), .CHANNELS(8)) u_dut (.REF_CLK(clk),
		.RST_N(rst_n), .CE(1'b1), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
		.HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready_out), .HRDATA(hrdata),
		.HREADYOUT(hready_out), .HRESP(hresp), .IN_VALID(in_valid), .IN_CHAN(in_chan),
		.IN_COUNT(in_count), .LINK_UP(link_up), .MSG_READY(msg_ready), .MSG_VALID(msg_valid),
		.MSG_CHAN(msg_chan), .MSG_TARGET_ADDR(msg_addr), .MSG_TARGET_REG(msg_reg),
		.MSG_DATA(msg_data));
	msg_sink u_sink (.clk(clk), .rst_n(rst_n), .link_en(link_en), .stall(stall),
		.msg_valid(msg_valid), .msg_chan(msg_chan), .msg_addr(msg_addr), .msg_reg(msg_reg),
		.msg_data(msg_data), .link_up(link_up), .msg_ready(msg_ready), .got_addr(got_addr),
		.got_reg(got_reg), .got_data(got_data), .cnt(cnt));

	// ----
	// Clock, watchdog and bench tasks
	// ----
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// Longest test is one heartbeat of 6000 cycles, so 30000 is ample
	initial
	begin
		repeat (30000) @(posedge clk);
		n_fail++;
		end_sim();
	end
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// One single AHB-Lite transfer; read data taken at the data phase edge
	task automatic bus(input logic w, input logic [31:0] a, d, output logic [31:0] q);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge clk); while (hready_out !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hready_out !== 1'b1);
		q = hrdata;
	endtask : bus
	task automatic wr(input logic [31:0] a, d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr
	task automatic rdc(input string nm, input logic [31:0] a, exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(nm, exp, q);
	endtask : rdc
	task automatic smp(input logic [2:0] ch, input logic [15:0] v);
		in_valid <= 1'b1;
		in_chan <= ch;
		in_count <= v;
		@(posedge clk);
		in_valid <= 1'b0;
	endtask : smp
	// Waits for one more accepted message of a channel, bounded
	task automatic wmsg(input int ch, input int lim, output int n);
		int c0;
		c0 = cnt[ch];
		n = 0;
		while (cnt[ch] == c0 && n < lim)
		begin
			@(posedge clk);
			n++;
		end
		chk("msg_arrives", 1, n < lim);
	endtask : wmsg
	function automatic logic [31:0] ra(input int ch, input int ofs);
		return 32'h100 + ch * 32'h20 + ofs;
	endfunction : ra
	task automatic end_sim();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_sim

	// ----
	// Test sequence
	// ----
	initial
	begin
		{hsel, hwrite, in_valid, stall, rst_n, htrans, haddr, hwdata, in_chan, in_count} = '0;
		link_en = 1'b1;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		rdc("ctrl", 32'h0, 32'h1);
		rdc("status", 32'h4, 32'h0002_0000);
		rdc("unmapped", 32'h800, 32'h0);
		wr(ra(3, 4), 32'h3E8);
		rdc("period_clamp", ra(3, 4), 32'h384);
		wr(ra(2, 4), 32'h1);
		$display("done reset");
		wr(ra(0, 12), 32'h1234);
		wr(ra(0, 8), 32'h0A00_0001);
		wr(ra(0, 4), 32'h1);
		stall <= 1'b1;
		// First message may predate the new mode, so the second is judged
		for (int i = 0; i < 11; i++)
		begin
			wr(ra(0, 0), {22'h0, mm[i], 8'h0});
			smp(3'h0, mi[i]);
			wmsg(0, 40, el);
			wmsg(0, 40, el);
			chk("map_out", {16'h0, mo[i]}, {16'h0, got_data});
			chk("target_reg", 32'h1234, {16'h0, got_reg});
			chk("target_addr", 32'h0A00_0001, got_addr);
		end
		stall <= 1'b0;
		wr(ra(0, 4), 32'h0);
		repeat (20) @(posedge clk);
		c = cnt[0];
		repeat (100) @(posedge clk);
		chk("silent_ch0", c, cnt[0]);
		$display("done map");
		wr(ra(1, 0), 32'h0A);
		wr(ra(1, 12), 32'h22);
		wr(ra(1, 8), 32'h0A00_0002);
		c = cnt[1];
		smp(3'h1, 16'h07CF);
		repeat (100) @(posedge clk);
		chk("below_span", c, cnt[1]);
		smp(3'h1, 16'h07D0);
		wmsg(1, 40, el);
		chk("span_send", 32'h7D0, {16'h0, got_data});
		smp(3'h1, 16'h09C4);
		wmsg(1, 6200, el);
		chk("hb_time", 1, el > 590 * TK);
		chk("hb_value", 32'h7D0, {16'h0, got_data});
		rdc("ref_hb", ra(1, 16), 32'h7D0);
		$display("done span");
		wr(ra(1, 4), 32'h2);
		wmsg(1, 60, el);
		chk("dual_live", 32'h9C4, {16'h0, got_data});
		rdc("ref_dual", ra(1, 16), 32'h9C4);
		link_en <= 1'b0;
		repeat (10) @(posedge clk);
		c = cnt[1];
		repeat (80) @(posedge clk);
		chk("held_down", c, cnt[1]);
		link_en <= 1'b1;
		wmsg(1, 60, el);
		$display("done dual");
		wr(32'h0, 32'h3);
		rdc("rst_cfg", ra(1, 0), 32'h0);
		rdc("rst_addr", ra(0, 8), 32'h0);
		rdc("rst_per", ra(1, 4), 32'h0);
		repeat (20) @(posedge clk);
		c = cnt[1];
		repeat (100) @(posedge clk);
		chk("restored_quiet", c, cnt[1]);
		chk("zero_addr_quiet", 0, cnt[2]);
		$display("done restore");
		end_sim();
	end
endmodule : testbench
